// File: hdl/bus_ratio_voltage_state_ctl.v
// Core ratio, voltage code and timed stop-grant control with observability register
`include "ratio_volt_defs.vh"

module bus_ratio_voltage_state_ctl #(
    parameter SG_PRESCALE = `SG_PRESCALE_CYCLES,
    parameter [3:0] STEPPING_ID = 4'h1 // Arbitrary value
) (
    // Clock and reset
    input wire REF_CLK_I,
    input wire RST_I,
    // Straps and pins
    input wire [2:0] RATIO_STRAP_PINS_I,
    input wire FLUSH_N_I,
    // Model-specific register access
    input wire [31:0] MSR_ADDR_I,
    input wire MSR_RD_I,
    input wire MSR_WR_I,
    input wire [63:0] MSR_WDATA_I,
    output reg [63:0] MSR_RDATA_O,
    output reg MSR_ACK_O,
    output reg MSR_ERR_O,
    // I/O access to the power management block
    input wire [15:0] IO_ADDR_I,
    input wire [3:0] IO_BE_I,
    input wire IO_RD_I,
    input wire IO_WR_I,
    input wire [31:0] IO_WDATA_I,
    output wire IO_HIT_O,
    output reg [31:0] IO_RDATA_O,
    output reg IO_ACK_O,
    // Clock multiplier and regulator
    output reg [2:0] EFF_RATIO_O,
    output reg [3:0] CORE_MULT_X2_O,
    output reg [4:0] VOLTAGE_ID_OUTPUTS_O,
    // Stop-grant status
    output reg STOP_GRANT_O,
    output reg SNOOP_BLOCK_O,
    // Flush sampling
    output reg FLUSH_AT_RESET_O,
    output reg FLUSH_REQ_O,
    // Boundary scan
    input wire SCAN_MODE_I,
    input wire TCK_I,
    input wire TDI_I,
    output reg TDO_O
);

    localparam ST_IDLE = 1'b0;
    localparam ST_STOPGRANT = 1'b1;

    // Pin synchronisers
    reg [2:0] strap_meta_reg;
    reg [2:0] strap_sync_reg;
    reg flush_meta_reg;
    reg flush_sync_reg;
    reg flush_prev_reg;
    reg scan_meta_reg;
    reg scan_sync_reg;
    reg tck_meta_reg;
    reg tck_sync_reg;
    reg tck_prev_reg;
    reg tdi_meta_reg;
    reg tdi_sync_reg;

    // Reset edge tracking
    reg rst_prev_reg;
    wire rst_fall;

    // State registers
    reg [2:0] strap_ratio_reg;
    reg [2:0] eff_ratio_reg;
    reg [4:0] vcode_reg;
    reg [15:0] pmb_reg;
    reg [11:0] ctl_reg;
    reg state_reg;
    reg state_next;
    reg [7:0] scan_shift_reg;

    // Decode
    wire io_block_hit;
    wire ctl_sel;
    wire [31:0] ctl_merged;
    wire timeout_written;
    wire sg_enter;
    wire sg_running;
    wire sg_expire;
    wire msr_obs_sel;
    wire msr_pmb_sel;
    wire [63:0] obs_word;
    wire tck_rise;
    wire tck_fall;
    reg [3:0] mult_x2;

    assign rst_fall = rst_prev_reg && !RST_I;

    // Two-flop synchronisers on strap, flush and scan pins; RST_I gets one flop for edge tracking; no reset so straps track during reset
    always @(posedge REF_CLK_I) begin
        strap_meta_reg <= RATIO_STRAP_PINS_I;
        strap_sync_reg <= strap_meta_reg;
        flush_meta_reg <= FLUSH_N_I;
        flush_sync_reg <= flush_meta_reg;
        scan_meta_reg <= SCAN_MODE_I;
        scan_sync_reg <= scan_meta_reg;
        tck_meta_reg <= TCK_I;
        tck_sync_reg <= tck_meta_reg;
        tdi_meta_reg <= TDI_I;
        tdi_sync_reg <= tdi_meta_reg;
        rst_prev_reg <= RST_I;
    end

    // Strap capture on reset release; straps must be stable through reset
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            strap_ratio_reg <= 3'h0;
        end else if (rst_fall) begin
            strap_ratio_reg <= strap_sync_reg;
        end
    end

    // Flush sampled once at release and then on every falling edge of FLUSH_N_I
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            FLUSH_AT_RESET_O <= 1'b0;
            FLUSH_REQ_O <= 1'b0;
            flush_prev_reg <= 1'b1;
        end else begin
            flush_prev_reg <= flush_sync_reg;
            if (rst_fall) begin
                FLUSH_AT_RESET_O <= !flush_sync_reg;
                FLUSH_REQ_O <= 1'b0;
            end else begin
                FLUSH_REQ_O <= flush_prev_reg && !flush_sync_reg;
            end
        end
    end

    // I/O block decode: enabled base, 16-byte window, control word at offset 8
    assign io_block_hit = pmb_reg[`PMB_EN_BIT] &&
        (IO_ADDR_I[15:4] == pmb_reg[`PMB_IOBASE_MSB:`PMB_IOBASE_LSB]);
    assign IO_HIT_O = io_block_hit && (IO_RD_I || IO_WR_I);
    assign ctl_sel = io_block_hit && (IO_ADDR_I[3:0] == `CTL_WORD_OFFSET);

    // Byte-lane merge; timeout field is write-only so its old value is zero
    assign ctl_merged[7:0] = IO_BE_I[0] ? IO_WDATA_I[7:0] : ctl_reg[7:0];
    assign ctl_merged[11:8] = IO_BE_I[1] ? IO_WDATA_I[11:8] : ctl_reg[11:8];
    assign ctl_merged[15:12] = IO_BE_I[1] ? IO_WDATA_I[15:12] : 4'h0;
    assign ctl_merged[23:16] = IO_BE_I[2] ? IO_WDATA_I[23:16] : 8'h00;
    assign ctl_merged[31:24] = IO_BE_I[3] ? IO_WDATA_I[31:24] : 8'h00;

    // Non-zero timeout starts the state; change mode 1 is reserved and refused
    assign timeout_written = ctl_merged[`CTL_TIMEOUT_MSB:`CTL_TIMEOUT_LSB] != 20'h0_0000;
    assign sg_enter = IO_WR_I && ctl_sel && timeout_written &&
        !ctl_merged[`CTL_CHG_MODE_BIT] && (state_reg == ST_IDLE);

    // Base register and control word writes
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            pmb_reg <= `PMB_RESET;
            ctl_reg <= `CTL_RESET | {7'h00, `VCODE_RESET};
        end else begin
            if (MSR_WR_I && msr_pmb_sel) begin
                pmb_reg <= MSR_WDATA_I[15:0] & 16'hFFF3;
            end
            if (IO_WR_I && ctl_sel) begin
                ctl_reg <= ctl_merged[11:0];
            end
        end
    end

    // Stop-grant duration timer
    sg_timer #(
        .PRESCALE(SG_PRESCALE),
        .CNT_W(20),
        .PRE_W(13)
    ) u_sg_timer (
        .clk(REF_CLK_I),
        .rst(RST_I),
        .load(sg_enter),
        .count(ctl_merged[`CTL_TIMEOUT_MSB:`CTL_TIMEOUT_LSB]),
        .running(sg_running),
        .expire(sg_expire)
    );

    // Stop-grant state machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (sg_enter) begin
                    state_next = ST_STOPGRANT;
                end
            end
            ST_STOPGRANT: begin
                if (sg_expire) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Ratio and voltage update: straps at release, programmed values on entry
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            eff_ratio_reg <= 3'h0;
            vcode_reg <= `VCODE_RESET;
        end else if (rst_fall) begin
            eff_ratio_reg <= strap_sync_reg;
        end else if (sg_enter) begin
            if (ctl_merged[`CTL_VCTL_BIT]) begin
                vcode_reg <= ctl_merged[`CTL_VOUT_MSB:`CTL_VOUT_LSB];
            end
            if (ctl_merged[`CTL_RMODE_MSB]) begin
                eff_ratio_reg <= ctl_merged[`CTL_IRATIO_MSB:`CTL_IRATIO_LSB];
            end
        end
    end

    // Ratio code to twice the multiplier, so half ratios stay integral
    always @* begin
        case (eff_ratio_reg)
            `RATIO_2P0: mult_x2 = 4'h4;
            `RATIO_3P0: mult_x2 = 4'h6;
            `RATIO_6P0: mult_x2 = 4'hC;
            `RATIO_3P5: mult_x2 = 4'h7;
            `RATIO_4P5: mult_x2 = 4'h9;
            `RATIO_5P0: mult_x2 = 4'hA;
            `RATIO_4P0: mult_x2 = 4'h8;
            `RATIO_5P5: mult_x2 = 4'hB;
            default: mult_x2 = 4'h9;
        endcase
    end

    // Multiplier, regulator and status outputs all registered
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            EFF_RATIO_O <= 3'h0;
            CORE_MULT_X2_O <= 4'h9;
            VOLTAGE_ID_OUTPUTS_O <= `VCODE_RESET;
            STOP_GRANT_O <= 1'b0;
            SNOOP_BLOCK_O <= 1'b0;
        end else begin
            EFF_RATIO_O <= eff_ratio_reg;
            CORE_MULT_X2_O <= mult_x2;
            VOLTAGE_ID_OUTPUTS_O <= vcode_reg;
            STOP_GRANT_O <= (state_next == ST_STOPGRANT);
            // Snoops are not served while stopped; system must hold them off
            SNOOP_BLOCK_O <= (state_next == ST_STOPGRANT);
        end
    end

    // Observability word; voltage field fixed at reset value
    assign obs_word = {48'h0000_0000_0000,
        strap_ratio_reg,
        `VCODE_RESET,
        eff_ratio_reg,
        1'b0,
        STEPPING_ID};

    assign msr_obs_sel = (MSR_ADDR_I == `MSR_STATE_OBSERVE_ADDR);
    assign msr_pmb_sel = (MSR_ADDR_I == `MSR_POWER_MGMT_BASE_ADDR);

    // Register reads: answer one clock after the strobe, error on unknown address
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            MSR_RDATA_O <= 64'h0000_0000_0000_0000;
            MSR_ACK_O <= 1'b0;
            MSR_ERR_O <= 1'b0;
        end else begin
            MSR_ACK_O <= MSR_RD_I || MSR_WR_I;
            MSR_ERR_O <= (MSR_RD_I || MSR_WR_I) && !msr_obs_sel && !msr_pmb_sel;
            if (MSR_RD_I && msr_obs_sel) begin
                MSR_RDATA_O <= obs_word;
            end else if (MSR_RD_I && msr_pmb_sel) begin
                MSR_RDATA_O <= {48'h0000_0000_0000, pmb_reg};
            end else if (MSR_RD_I) begin
                MSR_RDATA_O <= 64'h0000_0000_0000_0000;
            end
        end
    end

    // I/O reads of the block; timeout field reads as zero
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            IO_RDATA_O <= 32'h0000_0000;
            IO_ACK_O <= 1'b0;
        end else begin
            IO_ACK_O <= io_block_hit && (IO_RD_I || IO_WR_I);
            if (IO_RD_I && ctl_sel) begin
                IO_RDATA_O <= {20'h0_0000, ctl_reg};
            end else if (IO_RD_I && io_block_hit) begin
                IO_RDATA_O <= 32'h0000_0000;
            end
        end
    end

    // Test clock edges seen after synchronising; test clock must be well below bus clock
    assign tck_rise = !tck_prev_reg && tck_sync_reg;
    assign tck_fall = tck_prev_reg && !tck_sync_reg;

    // Scan cell over ratio and voltage outputs
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            tck_prev_reg <= 1'b0;
            scan_shift_reg <= 8'h00;
            TDO_O <= 1'b0;
        end else begin
            tck_prev_reg <= tck_sync_reg;
            if (!scan_sync_reg) begin
                scan_shift_reg <= {eff_ratio_reg, vcode_reg};
            end else if (tck_rise) begin
                scan_shift_reg <= {tdi_sync_reg, scan_shift_reg[7:1]};
            end
            if (scan_sync_reg && tck_fall) begin
                TDO_O <= scan_shift_reg[0];
            end
        end
    end

endmodule

// File: hdl/ratio_volt_defs.vh
// Constants for the bus-ratio and core-voltage state controller
`ifndef RATIO_VOLT_DEFS_VH
`define RATIO_VOLT_DEFS_VH

// Machine-specific register addresses
`define MSR_STATE_OBSERVE_ADDR 32'hC000_0087
`define MSR_POWER_MGMT_BASE_ADDR 32'hC000_0086

// Observability register field positions
`define OBS_STEP_LSB 0
`define OBS_STEP_MSB 3
`define OBS_L2_ABSENT_BIT 4
`define OBS_EFF_RATIO_LSB 5
`define OBS_EFF_RATIO_MSB 7
`define OBS_VCODE_LSB 8
`define OBS_VCODE_MSB 12
`define OBS_STRAP_RATIO_LSB 13
`define OBS_STRAP_RATIO_MSB 15

// Power management base register fields and reset value
`define PMB_EN_BIT 0
`define PMB_SPECIAL_CYCLE_BIT 1
`define PMB_IOBASE_LSB 4
`define PMB_IOBASE_MSB 15
`define PMB_RESET 16'h0000

// Ratio and voltage control word: byte offset in the 16-byte I/O block
`define CTL_WORD_OFFSET 4'h8
`define CTL_VOUT_LSB 0
`define CTL_VOUT_MSB 4
`define CTL_IRATIO_LSB 5
`define CTL_IRATIO_MSB 7
`define CTL_RMODE_LSB 8
`define CTL_RMODE_MSB 9
`define CTL_VCTL_BIT 10
`define CTL_CHG_MODE_BIT 11
`define CTL_TIMEOUT_LSB 12
`define CTL_TIMEOUT_MSB 31
`define CTL_RESET 12'h000

// Voltage code driven at reset
`define VCODE_RESET 5'h0A

// Stop-grant duration: bus clocks per timeout unit
`define SG_PRESCALE_CYCLES 4096

// Ratio codes
`define RATIO_2P0 3'h4
`define RATIO_3P0 3'h5
`define RATIO_6P0 3'h6
`define RATIO_3P5 3'h7
`define RATIO_4P5 3'h0
`define RATIO_5P0 3'h1
`define RATIO_4P0 3'h2
`define RATIO_5P5 3'h3

`endif

// File: hdl/sg_timer.v
// Stop-grant timeout counter: count times prescale bus clocks
`include "ratio_volt_defs.vh"

module sg_timer #(
    parameter PRESCALE = `SG_PRESCALE_CYCLES,
    parameter CNT_W = 20,
    parameter PRE_W = 13
) (
    input wire clk,
    input wire rst,
    input wire load,
    input wire [CNT_W-1:0] count,
    output reg running,
    output reg expire
);

    localparam [31:0] PRE_LAST_FULL = PRESCALE - 1;
    localparam [PRE_W-1:0] PRE_LAST = PRE_LAST_FULL[PRE_W-1:0];

    reg [CNT_W-1:0] units_reg;
    reg [PRE_W-1:0] pre_reg;

    // Units decrement on each prescale wrap; last wrap of last unit ends the span
    always @(posedge clk) begin
        if (rst) begin
            units_reg <= {CNT_W{1'b0}};
            pre_reg <= {PRE_W{1'b0}};
            running <= 1'b0;
        end else begin
            if (load && !running && count != {CNT_W{1'b0}}) begin
                units_reg <= count;
                pre_reg <= {PRE_W{1'b0}};
                running <= 1'b1;
            end else if (running) begin
                if (pre_reg == PRE_LAST) begin
                    pre_reg <= {PRE_W{1'b0}};
                    units_reg <= units_reg - 1'b1;
                    if (units_reg == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                        running <= 1'b0;
                    end
                end else begin
                    pre_reg <= pre_reg + 1'b1;
                end
            end
        end
    end

    // Expiry flagged in the last counted clock; a registered flag would add one clock
    always @* begin
        expire = running && (pre_reg == PRE_LAST) && (units_reg == {{(CNT_W-1){1'b0}}, 1'b1});
    end

endmodule

// File: testbench/ratio_volt_chk.sv
// Checker for the ratio and voltage state controller ports
module ratio_volt_chk #(
    parameter SG_PRESCALE = 4096,
    parameter [3:0] STEPPING_ID = 4'h1
) (
    // Clock and reset
    input wire REF_CLK_I,
    input wire RST_I,
    // Register access
    input wire [31:0] MSR_ADDR_I,
    input wire MSR_RD_I,
    input wire MSR_WR_I,
    input wire [63:0] MSR_RDATA_O,
    input wire MSR_ACK_O,
    // Control block access
    input wire [15:0] IO_ADDR_I,
    input wire [3:0] IO_BE_I,
    input wire IO_RD_I,
    input wire IO_WR_I,
    input wire [31:0] IO_WDATA_I,
    input wire IO_HIT_O,
    input wire IO_ACK_O,
    // Ratio, voltage and stop-grant
    input wire [2:0] EFF_RATIO_O,
    input wire [3:0] CORE_MULT_X2_O,
    input wire [4:0] VOLTAGE_ID_OUTPUTS_O,
    input wire STOP_GRANT_O,
    input wire SNOOP_BLOCK_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // Twice the multiplier, one nibble per ratio code
    localparam logic [31:0] X2 = 32'h7C64_B8A9;
    logic [19:0] n_reg;
    logic [4:0] v_reg;
    logic [2:0] r_reg;
    logic [31:0] cnt_reg;
    wire entry = IO_HIT_O && IO_WR_I && IO_ADDR_I[3:0] == 4'h8 && IO_BE_I == 4'hF
        && IO_WDATA_I[31:12] != 20'h0_0000 && !IO_WDATA_I[11] && !STOP_GRANT_O;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    // Timeout seen at entry and cycles spent in stop-grant
    always @(posedge REF_CLK_I) begin
        if (entry) begin
            n_reg <= IO_WDATA_I[31:12];
            v_reg <= IO_WDATA_I[4:0];
            r_reg <= IO_WDATA_I[7:5];
        end
        cnt_reg <= STOP_GRANT_O ? cnt_reg + 32'h1 : 32'h0;
    end
    sequence sg_write;
        entry;
    endsequence
    sequence ratio_settled;
        $stable(EFF_RATIO_O) [*2];
    endsequence
    msr_answer_a: assert property ((MSR_RD_I || MSR_WR_I) |=> MSR_ACK_O)
        else $error("register access not acknowledged");
    io_answer_a: assert property (IO_HIT_O && (IO_RD_I || IO_WR_I) |=> IO_ACK_O)
        else $error("control access not acknowledged");
    vid_reset_a: assert property (disable iff (1'b0) RST_I ##1 RST_I |-> VOLTAGE_ID_OUTPUTS_O == 5'h0A)
        else $error("voltage code wrong in reset");
    obs_fixed_a: assert property (MSR_RD_I && MSR_ADDR_I == 32'hC000_0087 |=>
        MSR_RDATA_O[4:0] == {1'b0, STEPPING_ID} && MSR_RDATA_O[12:8] == 5'h0A)
        else $error("fixed observe fields wrong");
    sg_enter_a: assert property (sg_write |=> STOP_GRANT_O)
        else $error("stop-grant not entered");
    vid_move_a: assert property (entry && IO_WDATA_I[10] |-> ##2 VOLTAGE_ID_OUTPUTS_O == v_reg)
        else $error("voltage code not moved");
    vid_keep_a: assert property (entry && !IO_WDATA_I[10] |=> $stable(VOLTAGE_ID_OUTPUTS_O) [*2])
        else $error("voltage code moved");
    ratio_move_a: assert property (entry && IO_WDATA_I[9] |-> ##2 EFF_RATIO_O == r_reg)
        else $error("ratio not moved");
    sg_length_a: assert property ($fell(STOP_GRANT_O) |-> cnt_reg == 32'(n_reg) * SG_PRESCALE)
        else $error("stop-grant length wrong");
    mult_map_a: assert property (ratio_settled |-> CORE_MULT_X2_O == X2[{EFF_RATIO_O, 2'b00} +: 4])
        else $error("multiplier does not match ratio");
    snoop_gate_a: assert property (SNOOP_BLOCK_O == STOP_GRANT_O)
        else $error("snoop block differs from stop-grant");
endmodule
bind bus_ratio_voltage_state_ctl ratio_volt_chk #(.SG_PRESCALE(SG_PRESCALE), .STEPPING_ID(STEPPING_ID)) chk (
    .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .MSR_ADDR_I(MSR_ADDR_I), .MSR_RD_I(MSR_RD_I),
    .MSR_WR_I(MSR_WR_I), .MSR_RDATA_O(MSR_RDATA_O), .MSR_ACK_O(MSR_ACK_O), .IO_ADDR_I(IO_ADDR_I),
    .IO_BE_I(IO_BE_I), .IO_RD_I(IO_RD_I), .IO_WR_I(IO_WR_I), .IO_WDATA_I(IO_WDATA_I),
    .IO_HIT_O(IO_HIT_O), .IO_ACK_O(IO_ACK_O), .EFF_RATIO_O(EFF_RATIO_O), .CORE_MULT_X2_O(CORE_MULT_X2_O),
    .VOLTAGE_ID_OUTPUTS_O(VOLTAGE_ID_OUTPUTS_O), .STOP_GRANT_O(STOP_GRANT_O), .SNOOP_BLOCK_O(SNOOP_BLOCK_O));

// File: testbench/ratio_volt_partner.sv
// System-side partner: ratio straps, core regulator and snoop source
module ratio_volt_partner #(
    parameter logic [2:0] STRAP = 3'h6
) (
    // Bus clock, regulator select code and snoop block
    input wire logic clk_i,
    input wire logic [4:0] vid_i,
    input wire logic block_i,
    // Straps, supply level and snoop request
    output logic [2:0] strap_o,
    output logic [4:0] level_o,
    output logic snoop_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Straps never move after power-up, so the reset sample is stable
    assign strap_o = STRAP;
    // Supply settles one clock late, as a slewing regulator would
    always @(posedge clk_i) level_o <= vid_i;
    // Snoops held off while stop-grant is signalled
    always @(posedge clk_i) snoop_o <= !block_i;
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the ratio and voltage state controller
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PRE = 4;
    localparam logic [2:0] STRAP = 3'h6;
    localparam logic [15:0] BASE = 16'h0400;
    logic clk, rst, flush_n, mrd, mwr, ird, iwr, mack, merr, ihit, iack, sg, sblk, freset, freq, snoop;
    logic scan, tck, tdo;
    logic [2:0] straps, eff;
    logic [3:0] ibe, mult;
    logic [4:0] voltage_code_field, level;
    logic [15:0] iaddr;
    logic [31:0] maddr, iwdata, irdata;
    logic [63:0] mwdata, mrdata;
    logic [3:0] x2tab [8] = '{4'h9, 4'hA, 4'h8, 4'hB, 4'h4, 4'h6, 4'hC, 4'h7};
    int mismatches = 0;
    int n_tests = 0;

    bus_ratio_voltage_state_ctl #(.SG_PRESCALE(PRE)) DUT (
        .REF_CLK_I(clk), .RST_I(rst), .RATIO_STRAP_PINS_I(straps), .FLUSH_N_I(flush_n),
        .MSR_ADDR_I(maddr), .MSR_RD_I(mrd), .MSR_WR_I(mwr), .MSR_WDATA_I(mwdata), .MSR_RDATA_O(mrdata),
        .MSR_ACK_O(mack), .MSR_ERR_O(merr), .IO_ADDR_I(iaddr), .IO_BE_I(ibe), .IO_RD_I(ird),
        .IO_WR_I(iwr), .IO_WDATA_I(iwdata), .IO_HIT_O(ihit), .IO_RDATA_O(irdata), .IO_ACK_O(iack),
        .EFF_RATIO_O(eff), .CORE_MULT_X2_O(mult), .VOLTAGE_ID_OUTPUTS_O(voltage_code_field), .STOP_GRANT_O(sg),
        .SNOOP_BLOCK_O(sblk), .FLUSH_AT_RESET_O(freset), .FLUSH_REQ_O(freq), .SCAN_MODE_I(scan),
        .TCK_I(tck), .TDI_I(1'b0), .TDO_O(tdo));
    ratio_volt_partner #(.STRAP(STRAP)) partner (
        .clk_i(clk), .vid_i(voltage_code_field), .block_i(sblk), .strap_o(straps), .level_o(level), .snoop_o(snoop));

    // Bus clock at 40 MHz
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // One-cycle register strobe, answer checked the cycle after
    task automatic msr(input logic wr, input logic [31:0] a, input logic [63:0] d);
        @(posedge clk);
        mrd <= !wr;
        mwr <= wr;
        maddr <= a;
        mwdata <= d;
        @(posedge clk);
        mrd <= 1'b0;
        mwr <= 1'b0;
        #1;
        `CHK(mack, 1'b1)
    endtask

    // Full-word write to the control word; hit is seen in the strobe cycle
    task automatic io(input logic [31:0] d, output logic h);
        @(posedge clk);
        iwr <= 1'b1;
        iaddr <= BASE | 16'h0008;
        ibe <= 4'hF;
        iwdata <= d;
        #1;
        h = ihit;
        @(posedge clk);
        iwr <= 1'b0;
        #1;
    endtask

    // One-cycle read of the control word, data taken with the acknowledge
    task automatic io_rd(output logic [31:0] d);
        @(posedge clk);
        ird <= 1'b1;
        iaddr <= BASE | 16'h0008;
        ibe <= 4'hF;
        @(posedge clk);
        ird <= 1'b0;
        #1;
        d = irdata;
    endtask

    function automatic logic [31:0] ctl(logic [19:0] n, logic v, logic [1:0] m, logic [2:0] r, logic [4:0] o);
        return {n, 1'b0, v, m, r, o};
    endfunction

    // Counts clocks until stop-grant drops, bounded against a hang
    task automatic wait_end(output int k);
        k = 0;
        while (sg === 1'b1 && k < 200) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask

    task automatic t_reset;
        `CHK(voltage_code_field, 5'h0A)
        `CHK(eff, STRAP)
        `CHK(freset, 1'b0)
        msr(1'b0, 32'hC000_0087, 64'h0);
        `CHK(mrdata[15:13], STRAP)
        `CHK(mrdata[12:8], 5'h0A)
        `CHK(mrdata[7:5], STRAP)
        `CHK(mrdata[4], 1'b0)
        `CHK(mrdata[3:0], 4'h1)
        msr(1'b0, 32'hC000_0090, 64'h0);
        `CHK(merr, 1'b1)
    endtask

    // Disabled block ignored; then entry with voltage and ratio held
    task automatic t_keep;
        logic h;
        int k;
        logic [31:0] d;
        io(ctl(20'h1, 1'b1, 2'b10, 3'h1, 5'h11), h);
        `CHK(h, 1'b0)
        `CHK(sg, 1'b0)
        msr(1'b1, 32'hC000_0086, {48'h0, BASE | 16'h0001});
        io(ctl(20'h1, 1'b0, 2'b00, 3'h3, 5'h1F), h);
        `CHK(iack, 1'b1)
        `CHK(sg, 1'b1)
        repeat (2) @(posedge clk);
        #1;
        `CHK(voltage_code_field, 5'h0A)
        `CHK(eff, STRAP)
        `CHK(snoop, 1'b0)
        wait_end(k);
        `CHK(k, PRE - 2)
        io_rd(d);
        `CHK(iack, 1'b1)
        `CHK(d, 32'h0000_007F)
    endtask

    // Every ratio code, each with its own voltage code
    task automatic t_ratio;
        logic h;
        int k;
        for (int i = 0; i < 8; i++) begin
            io(ctl(20'h2, 1'b1, 2'b10, i[2:0], 5'(i + 8)), h);
            `CHK(sg, 1'b1)
            repeat (2) @(posedge clk);
            #1;
            `CHK(voltage_code_field, 5'(i + 8))
            `CHK(eff, i[2:0])
            @(posedge clk);
            #1;
            `CHK(mult, x2tab[i])
            `CHK(level, 5'(i + 8))
            wait_end(k);
            `CHK(k, 2 * PRE - 3)
            msr(1'b0, 32'hC000_0087, 64'h0);
            `CHK(mrdata[7:5], i[2:0])
        end
    endtask

    // Run-time flush pulse, then a second reset with flush still held low
    task automatic t_flush;
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        flush_n <= 1'b0;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (freq === 1'b1) seen = 1'b1;
        end
        `CHK(seen, 1'b1)
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(freset, 1'b1)
        `CHK(freq, 1'b0)
        `CHK(eff, STRAP)
        `CHK(voltage_code_field, 5'h0A)
        @(posedge clk);
        flush_n <= 1'b1;
    endtask

    // Slow test clock shifts the chain; ratio above voltage code, bit 1 is the first bit seen at TDO
    task automatic t_scan;
        logic [7:0] w;
        w = {STRAP, 5'h0A};
        @(posedge clk);
        scan <= 1'b1;
        repeat (6) @(posedge clk);
        for (int b = 1; b < 8; b++) begin
            @(posedge clk);
            tck <= 1'b1;
            repeat (6) @(posedge clk);
            tck <= 1'b0;
            repeat (6) @(posedge clk);
            #1;
            `CHK(tdo, w[b])
        end
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        flush_n = 1'b1;
        scan = 1'b0;
        tck = 1'b0;
        mrd = 1'b0;
        mwr = 1'b0;
        ird = 1'b0;
        iwr = 1'b0;
        maddr = 32'h0;
        mwdata = 64'h0;
        iaddr = 16'h0;
        ibe = 4'h0;
        iwdata = 32'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        t_reset();
        t_keep();
        t_ratio();
        t_flush();
        t_scan();
        conclude();
    end

    // Watchdog, far beyond the few hundred clocks the tests need
    initial begin
        #100us;
        mismatches++;
        conclude();
    end
endmodule
